// ===== common/timer_prescaler_defs.svh
`ifndef TIMER_PRESCALER_DEFS_SVH
`define TIMER_PRESCALER_DEFS_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave.
`define GSC_OFFSET 4'h0
`define T0_CTRL_OFFSET 4'h4
`define T1_CTRL_OFFSET 4'h8
`define STATUS_OFFSET 4'hC

// ==========================================================================
// Field positions.
`define GSC_SHARED_RST_BIT 0
`define GSC_ASYNC_RST_BIT 1
`define GSC_SYNC_HOLD_BIT 7
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 2
`define CTRL_T16_OFF_BIT 7
`define STATUS_PRESC_LSB 0
`define STATUS_PIN_LSB 16

// ==========================================================================
// Reset values.
`define GSC_RESET 8'h00
`define SEL_RESET 3'h0
`define T16_OFF_RESET 1'b0
`define PRESC_RESET 10'h000

// ==========================================================================
// Prescaler width and the counter bits that close each divide tap.
`define PRESC_WIDTH 10
`define TAP_DIV8_BITS 3
`define TAP_DIV64_BITS 6
`define TAP_DIV256_BITS 8
`define TAP_DIV1024_BITS 10

`endif

// ===== common/timer_prescaler_pkg.sv
`include "timer_prescaler_defs.svh"

package timer_prescaler_pkg;

  // ========================================================================
  // Clock select encoding of each timer.
  typedef enum logic [2:0] {
    sel_stopped = 3'h0,
    sel_undivided = 3'h1,
    sel_div8 = 3'h2,
    sel_div64 = 3'h3,
    sel_div256 = 3'h4,
    sel_div1024 = 3'h5,
    sel_pin_fall = 3'h6,
    sel_pin_rise = 3'h7
  } clock_sel_t;

  // ========================================================================
  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } avmm_req_t;

  // Avalon-MM answer to the master.
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avmm_rsp_t;

  // Synchronised pin and its detected edges.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_edge_t;

  // Divide tap pulses of the shared prescaler.
  typedef struct packed {
    logic div8;
    logic div64;
    logic div256;
    logic div1024;
  } presc_taps_t;

endpackage : timer_prescaler_pkg

// ===== rtl/pin_edge_sync.sv
`timescale 1ns/100ps

module pin_edge_sync (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // External count pin.
  input wire logic count_pin,
  // Synchronised level and edge pulses.
  output timer_prescaler_pkg::pin_edge_t pin_edge
);
  import timer_prescaler_pkg::*;

  // ========================================================================
  // State of the posedge stages.
  typedef struct packed {
    logic sync;
    logic prev;
  } sync_state_t;

  logic latch_reg;
  sync_state_t state_reg;
  sync_state_t state_next;

  // The input stage captures the pin on the falling clock edge and holds it
  // for the whole cycle; the posedge stage after it then never sees a
  // changing input.
  always_ff @(negedge ref_clk) begin
    if (!rstn) begin
      latch_reg <= 1'b0;
    end else begin
      latch_reg <= count_pin;
    end
  end

  // Second stage reads only the input stage; the edge detector reads stages after it.
  always_comb begin
    state_next.sync = latch_reg;
    state_next.prev = state_reg.sync;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // One pulse per edge, one clock wide.
  assign pin_edge.level = state_reg.sync;
  assign pin_edge.rise = state_reg.sync & ~state_reg.prev;
  assign pin_edge.fall = ~state_reg.sync & state_reg.prev;

endmodule : pin_edge_sync

// ===== rtl/shared_timer_prescaler_sync.sv
// Operation
// - Free-running prescaler shared by both timers.
// - Prescaled first count within 1 to N+1.
// - Prescaler reset restarts both timers' periods.
// - Count pin sampled each clock, then edge-detected.
// - Posedge registers behind falling-edge capture stage.
// - One tick per selected pin edge.
// - Pin edge to counter update 2.5-3.5 cycles.
// - Pin ticks bypass the prescaler.
// - Sync hold keeps written reset bits.
// - Clearing sync hold clears both reset bits.
// - Shared reset bit self-clears unless held.
// - Stopped selection gives no ticks.
// - Selected source drives the timer tick.
// - Clock select encoding 0 to 7.
// - Pin counts even when driven as output.
`timescale 1ns/100ps
`include "timer_prescaler_defs.svh"

module shared_timer_prescaler_sync #(
  parameter int PRESC_W = `PRESC_WIDTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM register slave.
  input wire timer_prescaler_pkg::avmm_req_t avmm_req,
  output timer_prescaler_pkg::avmm_rsp_t avmm_rsp,
  // External count pins.
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  // Timer clock pulses.
  output logic timer0_tick,
  output logic timer1_tick
);
  import timer_prescaler_pkg::*;

  // ========================================================================
  // Elaboration checks.
  // The tap decode uses fixed counter bits, so a narrower prescaler cannot
  // produce the slowest tap.
  generate
    if (PRESC_W < `TAP_DIV1024_BITS) begin : g_bad_width
      $error("Prescaler width is too small for the slowest tap.");
    end
  endgenerate

  localparam int NUM_TIMERS = 2;

  // ========================================================================
  // Whole state of the block.
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic sync_hold;
    logic async_rst;
    logic shared_rst;
    logic [NUM_TIMERS-1:0][2:0] sel;
    logic t16_off;
    logic [PRESC_W-1:0] presc;
    logic [NUM_TIMERS-1:0] tick;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic [NUM_TIMERS-1:0] count_pins;
  pin_edge_t [NUM_TIMERS-1:0] pin_edges;
  presc_taps_t taps;
  logic [NUM_TIMERS-1:0] tick_sel;
  logic req;
  logic [31:0] read_value;

  // ========================================================================
  // Functions.
  // True when the request address names the given register word.
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offset);
    reg_hit = (addr[3:2] == offset[3:2]);
  endfunction : reg_hit

  // True when the low bits of the prescaler are all ones, closing a tap.
  function automatic logic tap_close(input logic [PRESC_W-1:0] cnt, input int bits);
    logic all_ones;
    all_ones = 1'b1;
    for (int b = 0; b < PRESC_W; b++) begin
      if (b < bits) begin
        all_ones = all_ones & cnt[b];
      end
    end
    tap_close = all_ones;
  endfunction : tap_close

  // Clock select logic: picks the timer clock pulse from the chosen source.
  function automatic logic pick_tick(input logic [2:0] sel, input presc_taps_t tp, input pin_edge_t pe);
    logic t;
    t = 1'b0;
    unique case (clock_sel_t'(sel))
      sel_stopped: t = 1'b0;
      sel_undivided: t = 1'b1;
      sel_div8: t = tp.div8;
      sel_div64: t = tp.div64;
      sel_div256: t = tp.div256;
      sel_div1024: t = tp.div1024;
      sel_pin_fall: t = pe.fall;
      sel_pin_rise: t = pe.rise;
    endcase
    pick_tick = t;
  endfunction : pick_tick

  // ========================================================================
  // Pin synchronisers, one per timer.
  // The pins are taken as inputs only; the timer counts whatever level is on
  // the pad, also when the port drives it, so software can count by toggling.
  assign count_pins = {timer1_count_pin, timer0_count_pin};

  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_pin
      pin_edge_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .count_pin(count_pins[i]),
        .pin_edge(pin_edges[i])
      );
    end
  endgenerate

  // ========================================================================
  // Prescaler taps.
  // A tap pulses in the last cycle of each divide period. While the shared
  // reset is held no tap fires, which halts every prescaled timer at once.
  always_comb begin
    taps.div8 = tap_close(state_reg.presc, `TAP_DIV8_BITS) & ~state_reg.shared_rst;
    taps.div64 = tap_close(state_reg.presc, `TAP_DIV64_BITS) & ~state_reg.shared_rst;
    taps.div256 = tap_close(state_reg.presc, `TAP_DIV256_BITS) & ~state_reg.shared_rst;
    taps.div1024 = tap_close(state_reg.presc, `TAP_DIV1024_BITS) & ~state_reg.shared_rst;
  end

  // ========================================================================
  // Per-timer source selection.
  // The power-off bit of the 16-bit timer stops its clock; software is
  // expected to clear it before selecting a source.
  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_sel
      if (i == 1) begin : g_t16
        assign tick_sel[i] = pick_tick(state_reg.sel[i], taps, pin_edges[i]) & ~state_reg.t16_off;
      end else begin : g_t8
        assign tick_sel[i] = pick_tick(state_reg.sel[i], taps, pin_edges[i]);
      end
    end
  endgenerate

  // ========================================================================
  // Register read value.
  // Reserved bits of every register read as zero.
  always_comb begin
    read_value = 32'h0000_0000;
    if (reg_hit(avmm_req.address, `GSC_OFFSET)) begin
      read_value[`GSC_SYNC_HOLD_BIT] = state_reg.sync_hold;
      read_value[`GSC_ASYNC_RST_BIT] = state_reg.async_rst;
      read_value[`GSC_SHARED_RST_BIT] = state_reg.shared_rst;
    end else if (reg_hit(avmm_req.address, `T0_CTRL_OFFSET)) begin
      read_value[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = state_reg.sel[0];
    end else if (reg_hit(avmm_req.address, `T1_CTRL_OFFSET)) begin
      read_value[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = state_reg.sel[1];
      read_value[`CTRL_T16_OFF_BIT] = state_reg.t16_off;
    end else if (reg_hit(avmm_req.address, `STATUS_OFFSET)) begin
      read_value[`STATUS_PRESC_LSB +: PRESC_W] = state_reg.presc;
      read_value[`STATUS_PIN_LSB] = pin_edges[0].level;
      read_value[`STATUS_PIN_LSB + 1] = pin_edges[1].level;
    end
  end

  // ========================================================================
  // Bus handshake.
  // Every access waits exactly one cycle; the data register is loaded in that
  // cycle so readdata comes straight from a flip-flop.
  assign req = avmm_req.read | avmm_req.write;
  assign avmm_rsp.waitrequest = req & ~state_reg.ack;
  assign avmm_rsp.readdata = state_reg.rdata;

  // ========================================================================
  // Next-state logic.
  always_comb begin
    state_next = state_reg;

    // Handshake: one wait cycle, then the access completes.
    state_next.ack = req & ~state_reg.ack;
    if (avmm_req.read && !state_reg.ack) begin
      state_next.rdata = read_value;
    end

    // Without sync hold, the reset bits live for one cycle only; with it
    // they keep what software wrote and the prescaled timers stay halted.
    if (!state_reg.sync_hold) begin
      state_next.shared_rst = 1'b0;
      state_next.async_rst = 1'b0;
    end

    // Register writes take effect at the edge that ends the access.
    if (avmm_req.write && state_reg.ack) begin
      if (reg_hit(avmm_req.address, `GSC_OFFSET)) begin
        state_next.sync_hold = avmm_req.writedata[`GSC_SYNC_HOLD_BIT];
        // Writing the hold bit to zero leaves the reset bits up for a single
        // cycle at most, so both timers leave reset on the same edge.
        state_next.shared_rst = avmm_req.writedata[`GSC_SHARED_RST_BIT];
        state_next.async_rst = avmm_req.writedata[`GSC_ASYNC_RST_BIT];
      end else if (reg_hit(avmm_req.address, `T0_CTRL_OFFSET)) begin
        state_next.sel[0] = avmm_req.writedata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      end else if (reg_hit(avmm_req.address, `T1_CTRL_OFFSET)) begin
        state_next.sel[1] = avmm_req.writedata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
        state_next.t16_off = avmm_req.writedata[`CTRL_T16_OFF_BIT];
      end
    end

    // The prescaler counts every cycle whatever the timers select; only the
    // shared reset stops it, and that restarts both timers' periods.
    if (state_reg.shared_rst) begin
      state_next.presc = '0;
    end else begin
      state_next.presc = state_reg.presc + PRESC_W'(1);
    end

    // Timer clock pulses are registered; a pin edge reaches the tick one and a half
    // to two and a half cycles after it and the counter one edge later.
    state_next.tick = tick_sel;
  end

  // ========================================================================
  // State register.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.sync_hold <= 1'(`GSC_RESET >> `GSC_SYNC_HOLD_BIT);
      state_reg.async_rst <= 1'(`GSC_RESET >> `GSC_ASYNC_RST_BIT);
      state_reg.shared_rst <= 1'(`GSC_RESET >> `GSC_SHARED_RST_BIT);
      state_reg.sel <= {NUM_TIMERS{`SEL_RESET}};
      state_reg.t16_off <= `T16_OFF_RESET;
      state_reg.presc <= PRESC_W'(`PRESC_RESET);
      state_reg.tick <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Outputs.
  assign timer0_tick = state_reg.tick[0];
  assign timer1_tick = state_reg.tick[1];

endmodule : shared_timer_prescaler_sync

// ===== tb/shared_timer_prescaler_sync_props.sv
`timescale 1ns/100ps
// ====================
// Checker of the bus handshake and of the tick paths.
module shared_timer_prescaler_sync_props #(
  parameter int PRESC_W = 10
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus.
  input wire timer_prescaler_pkg::avmm_req_t avmm_req,
  input wire timer_prescaler_pkg::avmm_rsp_t avmm_rsp,
  // Pins and ticks.
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic timer0_tick,
  input wire logic timer1_tick
);
  import timer_prescaler_pkg::*;
  logic done;
  logic wr;
  logic [1:0] wa;
  logic [2:0] sel0;
  logic [2:0] sel1;
  logic off1;
  logic hold;
  logic rst;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Completed transfers and the word they address.
  assign done = (avmm_req.read | avmm_req.write) & ~avmm_rsp.waitrequest;
  assign wr = done & avmm_req.write;
  assign wa = avmm_req.address[3:2];
  // Shadow of the control fields; a lone reset bit lives one cycle unless held.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {sel0, sel1, off1, hold, rst} <= '0;
    end else begin
      rst <= rst & hold;
      if (wr && wa == 2'h0) {hold, rst} <= {avmm_req.writedata[7], avmm_req.writedata[0]};
      if (wr && wa == 2'h1) sel0 <= avmm_req.writedata[2:0];
      if (wr && wa == 2'h2) {off1, sel1} <= {avmm_req.writedata[7], avmm_req.writedata[2:0]};
    end
  end
  wait_once_a: assert property (avmm_rsp.waitrequest |=> !avmm_rsp.waitrequest) else $error("Wait too long.");
  ack_single_a: assert property (done |=> !done) else $error("Answer held two cycles.");
  pin_rise_tick_a: assert property (
    sel0 == sel_pin_rise && $past(sel0) == sel_pin_rise && $rose(timer0_count_pin)
    |-> ##2 timer0_tick ##1 !timer0_tick) else $error("Rising pin tick wrong.");
  pin_fall_tick_a: assert property (
    sel1 == sel_pin_fall && $past(sel1) == sel_pin_fall && !off1 && $fell(timer1_count_pin)
    |-> ##2 timer1_tick ##1 !timer1_tick) else $error("Falling pin tick wrong.");
  tick_unique_a: assert property (
    timer0_tick && sel0 == sel_pin_rise && $past(sel0, 3) == sel_pin_rise
    |-> $past(timer0_count_pin, 2) && !$past(timer0_count_pin, 3)) else $error("Tick without edge.");
  stopped_idle_a: assert property (
    sel0 == sel_stopped && $past(sel0) == sel_stopped |-> !timer0_tick) else $error("Stopped timer ticks.");
  undivided_every_a: assert property (
    sel1 == sel_undivided && $past(sel1) == sel_undivided && !off1 && !$past(off1)
    |-> timer1_tick) else $error("Undivided tick missing.");
  div8_gap_a: assert property (
    sel0 == sel_div8 && $past(sel0) == sel_div8 && timer0_tick |=> (!timer0_tick || sel0 != sel_div8) [*7])
    else $error("Divide by 8 early.");
  restart_both_a: assert property (
    wr && wa == 2'h0 && !avmm_req.writedata[7] && (avmm_req.writedata[0] || rst) && sel0 == sel_div8
    && sel1 == sel_div8 && !off1 |=> ##1 !(timer0_tick || timer1_tick) [*7] ##[1:3] (timer0_tick && timer1_tick))
    else $error("Restart not shared.");
  hold_halt_a: assert property (
    hold && rst && $past(rst) && $past(sel0) == sel0 && sel0 >= sel_div8 && sel0 <= sel_div1024
    |-> !timer0_tick) else $error("Held timer ticks.");
  cover property (done && avmm_req.read);
  cover property (timer0_tick && sel0 == sel_pin_rise);
  cover property (hold && rst);
endmodule : shared_timer_prescaler_sync_props

bind shared_timer_prescaler_sync shared_timer_prescaler_sync_props #(.PRESC_W(PRESC_W)) u_props (
  .ref_clk(ref_clk), .rstn(rstn), .avmm_req(avmm_req), .avmm_rsp(avmm_rsp), .timer0_count_pin(timer0_count_pin),
  .timer1_count_pin(timer1_count_pin), .timer0_tick(timer0_tick), .timer1_tick(timer1_tick));

// ===== tb/count_pin_source.sv
`timescale 1ns/100ps
// ====================
// External count source on both pins.
module count_pin_source (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Bench control.
  input wire logic [1:0] run,
  input wire logic [3:0] half,
  // Count pins.
  output logic timer0_count_pin,
  output logic timer1_count_pin
);
  logic [3:0] cnt = 4'h0;
  // Each half period lasts half+1 cycles, never below three, which keeps the source slow enough.
  // A stopped pin keeps its level, so selects may be switched while it is quiet.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      {cnt, timer0_count_pin, timer1_count_pin} <= '0;
    end else if (cnt >= half) begin
      cnt <= 4'h0;
      timer0_count_pin <= timer0_count_pin ^ run[0];
      timer1_count_pin <= timer1_count_pin ^ run[1];
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : count_pin_source

// ===== tb/shared_timer_prescaler_sync_test.sv
`timescale 1ns/100ps
`include "timer_prescaler_defs.svh"
// ====================
// Self-checking bench of the shared prescaler block.
module shared_timer_prescaler_sync_test;
  import timer_prescaler_pkg::*;
  localparam int W = 2048;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  avmm_req_t avmm_req = '0;
  avmm_rsp_t avmm_rsp;
  logic timer0_count_pin;
  logic timer1_count_pin;
  logic timer0_tick;
  logic timer1_tick;
  logic [1:0] run = 2'h0;
  logic [3:0] half = 4'h2;
  logic clr = 1'b0;
  logic win = 1'b0;
  logic p0_d;
  logic p1_d;
  logic [15:0] c0, c1, e0, e1;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [2:0] s0;
  logic [2:0] s1;
  logic off;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  integer seed = 32'hc153;
  always #10 ref_clk = ~ref_clk;
  shared_timer_prescaler_sync u_dut (.ref_clk(ref_clk), .rstn(rstn), .avmm_req(avmm_req), .avmm_rsp(avmm_rsp),
    .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin), .timer0_tick(timer0_tick),
    .timer1_tick(timer1_tick));
  count_pin_source u_src (.ref_clk(ref_clk), .rstn(rstn), .run(run), .half(half),
    .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin));
  // Tick and pin edge counts over the window, plus the hang limit.
  always @(posedge ref_clk) begin
    p0_d <= timer0_count_pin;
    p1_d <= timer1_count_pin;
    cycles <= cycles + 1;
    if (clr) {c0, c1, e0, e1} <= '0;
    else if (win) begin
      c0 <= c0 + 16'(timer0_tick);
      c1 <= c1 + 16'(timer1_tick);
      e0 <= e0 + 16'(timer0_count_pin & ~p0_d);
      e1 <= e1 + 16'(~timer1_count_pin & p1_d);
    end
    if (cycles == 40000) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t timeout", $time);
      end_of_test;
    end
  end
  // One transfer; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avmm_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    @(posedge ref_clk);
    while (avmm_rsp.waitrequest !== 1'b0) @(posedge ref_clk);
    rd = avmm_rsp.readdata;
    avmm_req <= '0;
  endtask : bus
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Settles four cycles after a write, then counts over n edges.
  task automatic measure(input int n);
    repeat (4) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    win <= 1'b1;
    repeat (n) @(posedge ref_clk);
    win <= 1'b0;
    @(posedge ref_clk);
  endtask : measure
  // Ticks in a window of W cycles; W is a multiple of every divisor, so the count is exact.
  function automatic logic [15:0] ticks(input logic [2:0] s, input logic gate);
    if (gate) return 16'h0000;
    case (s)
      sel_undivided: return 16'(W);
      sel_div8: return 16'(W / 8);
      sel_div64: return 16'(W / 64);
      sel_div256: return 16'(W / 256);
      sel_div1024: return 16'(W / 1024);
      default: return 16'h0000;
    endcase
  endfunction : ticks
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Main sequence.
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 4'(i * 4), 32'h0000_0000);
      check(rd, 32'h0000_0000);
    end
    bus(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    rd2 = rd;
    bus(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    check(rd - rd2 & 32'h0000_03ff, 32'h0000_0003);
    bus(1'b1, `GSC_OFFSET, 32'h0000_0003);
    bus(1'b0, `GSC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Random selects, the slowest tap and the undivided clock first.
    for (int i = 0; i < 6; i++) begin
      s0 = 3'({$random(seed)} % 6);
      s1 = 3'({$random(seed)} % 6);
      off = 1'($random(seed));
      if (i == 0) {s0, s1, off} = {sel_div1024, sel_undivided, 1'b0};
      bus(1'b1, `T0_CTRL_OFFSET, {29'h0000_0000, s0});
      bus(1'b1, `T1_CTRL_OFFSET, {24'h00_0000, off, 4'h0, s1});
      measure(W);
      check(32'(c0), 32'(ticks(s0, 1'b0)));
      check(32'(c1), 32'(ticks(s1, off)));
    end
    // Pin modes, switched while both pins are quiet.
    bus(1'b1, `T0_CTRL_OFFSET, {29'h0000_0000, sel_pin_rise});
    bus(1'b1, `T1_CTRL_OFFSET, {29'h0000_0000, sel_pin_fall});
    half <= 4'(2 + {$random(seed)} % 4);
    fork
      measure(300);
      begin
        repeat (6) @(posedge ref_clk);
        run <= 2'h3;
        repeat (250) @(posedge ref_clk);
        run <= 2'h0;
      end
    join
    check({c0, c1}, {e0, e1});
    bus(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    check(rd & 32'h0003_0000, {14'h0000, timer1_count_pin, timer0_count_pin, 16'h0000});
    // Shared reset, then hold and a common start of both timers.
    bus(1'b1, `T0_CTRL_OFFSET, {29'h0000_0000, sel_div8});
    bus(1'b1, `T1_CTRL_OFFSET, {29'h0000_0000, sel_div8});
    bus(1'b1, `GSC_OFFSET, 32'h0000_0001);
    repeat (16) @(posedge ref_clk);
    bus(1'b1, `GSC_OFFSET, 32'h0000_0081);
    measure(200);
    check({c0, c1}, 32'h0000_0000);
    bus(1'b0, `GSC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0081);
    bus(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    check(rd & 32'h0000_03ff, 32'h0000_0000);
    bus(1'b1, `GSC_OFFSET, 32'h0000_0000);
    measure(64);
    check({c0, c1}, 32'h0008_0008);
    bus(1'b0, `GSC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    end_of_test;
  end
endmodule : shared_timer_prescaler_sync_test
